// File: core/dbrw_pkg.sv
// shared constants and types for the burst read/write link
package dbrw_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// widths; one clock carries two 16-bit beats
	localparam int DQ_W   = 32;
	localparam int BANK_W = 3;
	localparam int ADDR_W = 13;
	localparam int COL_W  = 10;
	localparam int LAT_W  = 5;
	localparam int CNT_W  = 8;
	localparam int BEAT_W = 2;
	localparam int COL_LO = 3;
	localparam int COL_HI = 4;
	localparam int SLOT_W = BANK_W + COL_HI - COL_LO + 1;
	localparam int MEM_D  = 2 ** (SLOT_W + BEAT_W);
	localparam int PIPE_D = 2 ** (LAT_W + 1);
	localparam int FIFO_D = 32;
	localparam int BURST_BIT = 12;

	//////////////////////////////////////////////////////////////////////////////
	// burst length field and burst lengths in clocks of data
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam logic [2:0] LEN_BL8   = 3'h4;
	localparam logic [2:0] LEN_BC4   = 3'h2;
	localparam logic [2:0] LEN_ONE   = 3'h1;
	localparam logic [BEAT_W-1:0] BEAT_ZERO = 2'h0;
	localparam logic [BEAT_W-1:0] BEAT_ONE  = 2'h1;
	localparam logic [LAT_W:0]    LAT_PRE   = 6'h2;
	localparam logic [LAT_W:0]    LAT_DATA  = 6'h1;

	//////////////////////////////////////////////////////////////////////////////
	// timing, times in ps, counts rounded up to whole clocks
	localparam int CLK_PS      = 20000;
	localparam int CCD_CYC     = 4;
	localparam int RTP_MIN_CYC = 4;
	localparam int RTP_PS      = 7500;
	localparam int RCD_PS      = 15000;
	localparam int RP_PS       = 15000;
	localparam int RAS_PS      = 36000;
	localparam int RC_PS       = 51000;
	localparam int WR_PS       = 15000;
	localparam int RTP_NS_CYC  = (RTP_PS + CLK_PS - 1) / CLK_PS;
	localparam int RTP_CYC     = (RTP_NS_CYC > RTP_MIN_CYC) ? RTP_NS_CYC : RTP_MIN_CYC;
	localparam int RCD_CYC     = (RCD_PS + CLK_PS - 1) / CLK_PS;
	localparam int RP_CYC      = (RP_PS + CLK_PS - 1) / CLK_PS;
	localparam int RAS_CYC     = (RAS_PS + CLK_PS - 1) / CLK_PS;
	localparam int RC_CYC      = (RC_PS + CLK_PS - 1) / CLK_PS;
	localparam int WR_CYC      = (WR_PS + CLK_PS - 1) / CLK_PS;
	localparam logic [CNT_W-1:0] AGE_ONE  = 8'h01;
	localparam logic [CNT_W-1:0] CCD_CNT  = CNT_W'(CCD_CYC);
	localparam logic [CNT_W-1:0] RTP_CNT  = CNT_W'(RTP_CYC);
	localparam logic [CNT_W-1:0] RCD_CNT  = CNT_W'(RCD_CYC);
	localparam logic [CNT_W-1:0] RP_CNT   = CNT_W'(RP_CYC);
	localparam logic [CNT_W-1:0] RAS_CNT  = CNT_W'(RAS_CYC);
	localparam logic [CNT_W-1:0] RAS_LEFT = CNT_W'(RAS_CYC - RCD_CYC);
	localparam logic [CNT_W-1:0] RC_CNT   = CNT_W'(RC_CYC);
	localparam logic [CNT_W-1:0] WR_CNT   = CNT_W'(WR_CYC);
	localparam logic [CNT_W-1:0] WIN_PAD  = 8'h02;

	//////////////////////////////////////////////////////////////////////////////
	// command codes and queued request
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD  = 3'h2,
		CMD_WR  = 3'h3,
		CMD_PRE = 3'h4
	} dbrw_cmd_t;

	typedef struct packed {
		logic              write;
		logic              chop;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] row;
		logic [COL_W-1:0]  col;
		logic [DQ_W-1:0]   seed;
	} dbrw_req_t;

endpackage : dbrw_pkg

// File: core/dbrw_link.sv
// command, address and data lines between controller and device
`timescale 1ns/10ps
`default_nettype none

interface dbrw_link;
	dbrw_pkg::dbrw_cmd_t                cmd;
	logic [dbrw_pkg::BANK_W-1:0]        bank;
	logic [dbrw_pkg::ADDR_W-1:0]        addr;
	// controller drive of the two-way data and strobe
	logic [dbrw_pkg::DQ_W-1:0]          ctlDq;
	logic                               ctlDqOe;
	logic                               ctlDqsOe;
	// device drive of the two-way data and strobe
	logic [dbrw_pkg::DQ_W-1:0]          devDq;
	logic                               devDqOe;
	logic                               devDqsOe;
	logic                               devDqs;

	modport device (
		input  cmd, bank, addr, ctlDq, ctlDqOe, ctlDqsOe,
		output devDq, devDqOe, devDqsOe, devDqs
	);
	modport controller (
		output cmd, bank, addr, ctlDq, ctlDqOe, ctlDqsOe,
		input  devDq, devDqOe, devDqsOe, devDqs
	);
endinterface : dbrw_link

`default_nettype wire

// File: core/dbrw_device.sv
// device end: burst decode, read/write data timing, data store, timing monitor
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - A12 low chops to four, high eight, in mode 01
// - A12 never part of column address
// - column commands at least four clocks apart
// - A12 high gives eight beats, modes 00/01
// - read to precharge at least AL plus tRTP
// - tRTP is max of four clocks, 7.5ns
// - activate-to-precharge minimum also holds after read
// - reactivate after precharge time and row cycle
// - strobe at RL-1, data at RL
// - release at RL+4 eight, RL+2 chopped
// - strobe timing valid only with locked loop
// - setup/hold slip corrupts only addressed location
// - strobe violations corrupt location, never hang
// - other violations need full reset sequence
//////////////////////////////////////////////////////////////////////////////

module dbrw_device (
	// clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	// link to the controller
	dbrw_link.device                          link,
	// mode settings
	input  wire logic [1:0]                   burstMode,
	input  wire logic [dbrw_pkg::LAT_W-1:0]   addLatency,
	input  wire logic [dbrw_pkg::LAT_W-1:0]   casLatency,
	input  wire logic [dbrw_pkg::LAT_W-1:0]   cwLatency,
	input  wire logic                         dllLocked,
	// status
	output logic                              strobeTrusted,
	output logic                              writeStrobeFault,
	output logic                              timingFault
);

	localparam int BANKS = 2 ** dbrw_pkg::BANK_W;
	localparam int BW    = dbrw_pkg::BANK_W;
	localparam int CW    = dbrw_pkg::CNT_W;
	localparam int PADW  = dbrw_pkg::CNT_W - dbrw_pkg::LAT_W;

	typedef struct packed {
		logic                          valid;
		logic                          write;
		logic                          chop;
		logic [dbrw_pkg::SLOT_W-1:0]   slot;
	} dbrw_slot_t;

	logic [dbrw_pkg::LAT_W:0]          readLat;
	logic [dbrw_pkg::LAT_W:0]          writeLat;
	logic                              isRead;
	logic                              isWrite;
	logic                              isCol;
	logic                              isAct;
	logic                              isPre;
	logic                              cmdChop;
	dbrw_slot_t                        next_slot;
	dbrw_slot_t                        pipe [dbrw_pkg::PIPE_D];
	dbrw_slot_t                        preTap;
	dbrw_slot_t                        rdTap;
	dbrw_slot_t                        wrTap;
	logic                              preStart;
	logic                              rdStart;
	logic                              wrStart;
	logic [2:0]                        rdLeft;
	logic [dbrw_pkg::BEAT_W-1:0]       rdBeat;
	logic [dbrw_pkg::SLOT_W-1:0]       rdSlot;
	logic                              rdBusy;
	logic [2:0]                        wrLeft;
	logic [dbrw_pkg::BEAT_W-1:0]       wrBeat;
	logic [dbrw_pkg::SLOT_W-1:0]       wrSlot;
	logic                              wrMissed;
	logic [dbrw_pkg::DQ_W-1:0]         store [dbrw_pkg::MEM_D];
	logic [CW-1:0]                     colAge;
	logic [CW-1:0]                     actAge [BANKS];
	logic [CW-1:0]                     preAge [BANKS];
	logic [CW-1:0]                     rdAge [BANKS];
	logic [CW-1:0]                     rtpLimit;
	logic [BANKS-1:0]                  bankBad;
	logic                              colBad;

	function automatic logic [2:0] burstLen(input logic chop);
		burstLen = chop ? dbrw_pkg::LEN_BC4 : dbrw_pkg::LEN_BL8;
	endfunction : burstLen

	// saturating age: stays at all ones so a long-idle bank never looks fresh
	function automatic logic [CW-1:0] nextAge(input logic hit, input logic [CW-1:0] cur);
		if (hit) begin
			nextAge = dbrw_pkg::AGE_ONE;
		end else if (cur != '1) begin
			nextAge = cur + dbrw_pkg::AGE_ONE;
		end else begin
			nextAge = cur;
		end
	endfunction : nextAge

	//////////////////////////////////////////////////////////////////////////////
	// command decode

	assign readLat  = {1'b0, addLatency} + {1'b0, casLatency};
	assign writeLat = {1'b0, addLatency} + {1'b0, cwLatency};
	assign isRead   = link.cmd == dbrw_pkg::CMD_RD;
	assign isWrite  = link.cmd == dbrw_pkg::CMD_WR;
	assign isAct    = link.cmd == dbrw_pkg::CMD_ACT;
	assign isPre    = link.cmd == dbrw_pkg::CMD_PRE;
	assign isCol    = isRead | isWrite;

	always_comb begin
		unique case (burstMode)
			dbrw_pkg::BL_FIXED8: cmdChop = 1'b0;
			dbrw_pkg::BL_OTF:    cmdChop = ~link.addr[dbrw_pkg::BURST_BIT];
			default:             cmdChop = 1'b1;
		endcase
	end

	// slot comes from the bank and the column bits 4:3 only
	assign next_slot = {isCol, isWrite, cmdChop, link.bank,
		link.addr[dbrw_pkg::COL_HI:dbrw_pkg::COL_LO]};

	//////////////////////////////////////////////////////////////////////////////
	// latency pipeline, one stage per clock after the command edge

	generate
		for (genvar i = 0; i < dbrw_pkg::PIPE_D; i++) begin : g_pipe
			if (i == 0) begin : g_head
				always_ff @(posedge core_clk) begin
					if (sys_rst) begin
						pipe[i] <= '0;
					end else begin
						pipe[i] <= next_slot;
					end
				end
			end else begin : g_body
				always_ff @(posedge core_clk) begin
					if (sys_rst) begin
						pipe[i] <= '0;
					end else begin
						pipe[i] <= pipe[i-1];
					end
				end
			end
		end
	endgenerate

	// taps need a read latency of two or more and a write latency of one or more
	assign preTap   = pipe[readLat - dbrw_pkg::LAT_PRE];
	assign rdTap    = pipe[readLat - dbrw_pkg::LAT_DATA];
	assign wrTap    = pipe[writeLat - dbrw_pkg::LAT_DATA];
	assign preStart = preTap.valid & ~preTap.write;
	assign rdStart  = rdTap.valid & ~rdTap.write;
	assign wrStart  = wrTap.valid & wrTap.write;
	assign rdBusy   = rdLeft != '0;

	//////////////////////////////////////////////////////////////////////////////
	// read burst

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdLeft <= '0;
			rdBeat <= '0;
			rdSlot <= '0;
		end else if (rdStart) begin
			rdLeft <= burstLen(rdTap.chop) - dbrw_pkg::LEN_ONE;
			rdBeat <= dbrw_pkg::BEAT_ONE;
			rdSlot <= rdTap.slot;
		end else if (rdBusy) begin
			rdLeft <= rdLeft - dbrw_pkg::LEN_ONE;
			rdBeat <= rdBeat + dbrw_pkg::BEAT_ONE;
		end
	end

	// strobe low through the preamble clock, high while data stands
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			link.devDqsOe <= 1'b0;
			link.devDqOe  <= 1'b0;
			link.devDqs   <= 1'b0;
			link.devDq    <= '0;
		end else begin
			link.devDqsOe <= preStart | rdStart | rdBusy;
			link.devDqOe  <= rdStart | rdBusy;
			link.devDqs   <= rdStart | rdBusy;
			if (rdStart) begin
				link.devDq <= store[{rdTap.slot, dbrw_pkg::BEAT_ZERO}];
			end else if (rdBusy) begin
				link.devDq <= store[{rdSlot, rdBeat}];
			end else begin
				link.devDq <= '0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			strobeTrusted <= 1'b0;
		end else begin
			strobeTrusted <= dllLocked;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// write burst: the beat count always runs out, so a bad strobe cannot stall it

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wrLeft           <= '0;
			wrBeat           <= '0;
			wrSlot           <= '0;
			wrMissed         <= 1'b0;
			writeStrobeFault <= 1'b0;
		end else begin
			writeStrobeFault <= 1'b0;
			if (wrStart) begin
				wrLeft   <= burstLen(wrTap.chop);
				wrBeat   <= dbrw_pkg::BEAT_ZERO;
				wrSlot   <= wrTap.slot;
				wrMissed <= 1'b0;
			end else if (wrLeft != '0) begin
				wrLeft   <= wrLeft - dbrw_pkg::LEN_ONE;
				wrBeat   <= wrBeat + dbrw_pkg::BEAT_ONE;
				wrMissed <= wrMissed | ~link.ctlDqsOe;
				if (wrLeft == dbrw_pkg::LEN_ONE) begin
					writeStrobeFault <= wrMissed | ~link.ctlDqsOe;
				end
			end
		end
	end

	generate
		for (genvar m = 0; m < dbrw_pkg::MEM_D; m++) begin : g_store
			always_ff @(posedge core_clk) begin
				// only the addressed slot can take bad data
				if (wrLeft != '0 && {wrSlot, wrBeat} == m) begin
					store[m] <= link.ctlDq;
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////
	// timing monitor; a fault stays until reset, since only a full re-init recovers

	assign rtpLimit = {{PADW{1'b0}}, addLatency} + dbrw_pkg::RTP_CNT;
	assign colBad   = isCol & (colAge < dbrw_pkg::CCD_CNT);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			colAge <= '1;
		end else begin
			colAge <= nextAge(isCol, colAge);
		end
	end

	generate
		for (genvar b = 0; b < BANKS; b++) begin : g_bank
			logic hit;
			assign hit = link.bank == BW'(b);
			assign bankBad[b] = hit & ((isPre & ((rdAge[b] < rtpLimit)
				| (actAge[b] < dbrw_pkg::RAS_CNT)))
				| (isAct & ((preAge[b] < dbrw_pkg::RP_CNT)
				| (actAge[b] < dbrw_pkg::RC_CNT))));
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					actAge[b] <= '1;
					preAge[b] <= '1;
					rdAge[b]  <= '1;
				end else begin
					actAge[b] <= nextAge(hit & isAct, actAge[b]);
					preAge[b] <= nextAge(hit & isPre, preAge[b]);
					rdAge[b]  <= nextAge(hit & isRead, rdAge[b]);
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			timingFault <= 1'b0;
		end else if (colBad | (|bankBad)) begin
			timingFault <= 1'b1;
		end
	end

endmodule : dbrw_device

`default_nettype wire

// File: core/dbrw_controller.sv
// controller end: request queue, close-page sequencer, write drive, read capture
`timescale 1ns/10ps
`default_nettype none

module dbrw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	// filling side
	input  wire logic               inValid,
	output logic                    inReady,
	input  wire logic [WIDTH-1:0]   inData,
	// draining side
	output logic                    outValid,
	input  wire logic               outReady,
	output logic [WIDTH-1:0]        outData
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]   store [DEPTH];
	logic [AW-1:0]      wrPtr;
	logic [AW-1:0]      rdPtr;
	logic [AW:0]        count;
	logic [AW:0]        next_count;
	logic               push;
	logic               pop;

	assign push       = inValid & inReady;
	assign pop        = outValid & outReady;
	assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign outData    = store[rdPtr];

	always_ff @(posedge core_clk) begin
		if (push) begin
			store[wrPtr] <= inData;
		end
	end

	// flags registered from the next count so both stay honest
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wrPtr    <= '0;
			rdPtr    <= '0;
			count    <= '0;
			inReady  <= 1'b0;
			outValid <= 1'b0;
		end else begin
			wrPtr    <= wrPtr + AW'(push);
			rdPtr    <= rdPtr + AW'(pop);
			count    <= next_count;
			inReady  <= next_count != (AW+1)'(DEPTH);
			outValid <= next_count != '0;
		end
	end

endmodule : dbrw_fifo

//////////////////////////////////////////////////////////////////////////////

module dbrw_controller (
	// clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	// link to the device
	dbrw_link.controller                      link,
	// latency settings
	input  wire logic [dbrw_pkg::LAT_W-1:0]   addLatency,
	input  wire logic [dbrw_pkg::LAT_W-1:0]   casLatency,
	input  wire logic [dbrw_pkg::LAT_W-1:0]   cwLatency,
	// request queue
	input  wire logic                         usrReqValid,
	output logic                              usrReqReady,
	input  wire dbrw_pkg::dbrw_req_t          usrReq,
	// read data
	output logic                              usrRdValid,
	output logic [dbrw_pkg::DQ_W-1:0]         usrRdData
);

	localparam int CW   = dbrw_pkg::CNT_W;
	localparam int PADW = dbrw_pkg::CNT_W - dbrw_pkg::LAT_W;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_RCD  = 4'h2,
		S_HOLD = 4'h4,
		S_RP   = 4'h8
	} dbrw_state_t;

	dbrw_state_t              state;
	dbrw_pkg::dbrw_req_t      head;
	dbrw_pkg::dbrw_req_t      req;
	logic                     headValid;
	logic                     take;
	logic [CW-1:0]            waitCnt;
	logic [CW-1:0]            actAge;
	logic [CW-1:0]            rdHold;
	logic [CW-1:0]            wrHold;
	logic [CW-1:0]            readLat;
	logic [CW-1:0]            writeLat;
	logic                     issueCol;
	logic [CW-1:0]            wrDelay;
	logic [2:0]               wrLeft;
	logic [CW-1:0]            rdWin;

	dbrw_fifo #(
		.WIDTH ($bits(dbrw_pkg::dbrw_req_t)),
		.DEPTH (dbrw_pkg::FIFO_D)
	) u_queue (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.inValid  (usrReqValid),
		.inReady  (usrReqReady),
		.inData   (usrReq),
		.outValid (headValid),
		.outReady (take),
		.outData  (head)
	);

	assign readLat  = {{PADW{1'b0}}, addLatency} + {{PADW{1'b0}}, casLatency};
	assign writeLat = {{PADW{1'b0}}, addLatency} + {{PADW{1'b0}}, cwLatency};
	// one timer for all banks: simpler, costs throughput on bank changes
	assign take     = (state == S_IDLE) & headValid & (actAge >= dbrw_pkg::RC_CNT);
	assign issueCol = (state == S_RCD) & (waitCnt == dbrw_pkg::AGE_ONE);

	always_comb begin
		rdHold = {{PADW{1'b0}}, addLatency} + dbrw_pkg::RTP_CNT;
		if (rdHold < dbrw_pkg::RAS_LEFT) begin
			rdHold = dbrw_pkg::RAS_LEFT;
		end
		wrHold = writeLat + CW'(dbrw_pkg::LEN_BL8) + dbrw_pkg::WR_CNT;
		if (wrHold < dbrw_pkg::RAS_LEFT) begin
			wrHold = dbrw_pkg::RAS_LEFT;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// sequencer: activate, column, precharge; the gaps keep column commands apart

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state     <= S_IDLE;
			req       <= '0;
			waitCnt   <= '0;
			link.cmd  <= dbrw_pkg::CMD_NOP;
			link.bank <= '0;
			link.addr <= '0;
		end else begin
			link.cmd <= dbrw_pkg::CMD_NOP;
			unique case (state)
				S_IDLE: begin
					if (take) begin
						req       <= head;
						link.cmd  <= dbrw_pkg::CMD_ACT;
						link.bank <= head.bank;
						link.addr <= head.row;
						waitCnt   <= dbrw_pkg::RCD_CNT;
						state     <= S_RCD;
					end
				end
				S_RCD: begin
					if (issueCol) begin
						link.cmd  <= req.write ? dbrw_pkg::CMD_WR : dbrw_pkg::CMD_RD;
						link.addr <= {~req.chop, {(dbrw_pkg::ADDR_W - dbrw_pkg::COL_W - 1){1'b0}},
							req.col};
						waitCnt   <= req.write ? wrHold : rdHold;
						state     <= S_HOLD;
					end else begin
						waitCnt <= waitCnt - dbrw_pkg::AGE_ONE;
					end
				end
				S_HOLD: begin
					if (waitCnt == dbrw_pkg::AGE_ONE) begin
						link.cmd <= dbrw_pkg::CMD_PRE;
						waitCnt  <= dbrw_pkg::RP_CNT;
						state    <= S_RP;
					end else begin
						waitCnt <= waitCnt - dbrw_pkg::AGE_ONE;
					end
				end
				S_RP: begin
					if (waitCnt == dbrw_pkg::AGE_ONE) begin
						state <= S_IDLE;
					end else begin
						waitCnt <= waitCnt - dbrw_pkg::AGE_ONE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			actAge <= '1;
		end else if (take) begin
			actAge <= dbrw_pkg::AGE_ONE;
		end else if (actAge != '1) begin
			actAge <= actAge + dbrw_pkg::AGE_ONE;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// write data: beats count up from the request seed

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wrDelay       <= '0;
			wrLeft        <= '0;
			link.ctlDq    <= '0;
			link.ctlDqOe  <= 1'b0;
			link.ctlDqsOe <= 1'b0;
		end else begin
			if (issueCol & req.write) begin
				wrDelay <= writeLat + dbrw_pkg::AGE_ONE;
			end else if (wrDelay != '0) begin
				wrDelay <= wrDelay - dbrw_pkg::AGE_ONE;
			end
			if (wrDelay == dbrw_pkg::AGE_ONE) begin
				wrLeft        <= (req.chop ? dbrw_pkg::LEN_BC4 : dbrw_pkg::LEN_BL8)
					- dbrw_pkg::LEN_ONE;
				link.ctlDq    <= req.seed;
				link.ctlDqOe  <= 1'b1;
				link.ctlDqsOe <= 1'b1;
			end else if (wrLeft != '0) begin
				wrLeft     <= wrLeft - dbrw_pkg::LEN_ONE;
				link.ctlDq <= link.ctlDq + 1'b1;
			end else begin
				link.ctlDqOe  <= 1'b0;
				link.ctlDqsOe <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// read capture, qualified by strobe and by a window counted from the read

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdWin      <= '0;
			usrRdValid <= 1'b0;
			usrRdData  <= '0;
		end else begin
			if (issueCol & ~req.write) begin
				rdWin <= readLat + CW'(dbrw_pkg::LEN_BL8) + dbrw_pkg::WIN_PAD;
			end else if (rdWin != '0) begin
				rdWin <= rdWin - dbrw_pkg::AGE_ONE;
			end
			usrRdValid <= link.devDqOe & link.devDqs & (rdWin != '0);
			usrRdData  <= link.devDq;
		end
	end

endmodule : dbrw_controller

`default_nettype wire

// File: tb/dbrw_link_monitor.sv
// link protocol checker for the burst read/write link
`timescale 1ns/10ps
`default_nettype none
module dbrw_link_monitor (
	// clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	// link lines
	input  wire dbrw_pkg::dbrw_cmd_t          cmd,
	input  wire logic [dbrw_pkg::ADDR_W-1:0]  addr,
	input  wire logic [1:0]                   burstMode,
	input  wire logic                         ctlDqOe,
	input  wire logic                         ctlDqsOe,
	input  wire logic                         devDqOe,
	input  wire logic                         devDqsOe,
	input  wire logic                         devDqs
);
	logic isRd;
	logic isWr;
	logic isAct;
	assign isRd  = cmd == dbrw_pkg::CMD_RD;
	assign isWr  = cmd == dbrw_pkg::CMD_WR;
	assign isAct = cmd == dbrw_pkg::CMD_ACT;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	//////////////////////////////////////////////////////////////////////////////
	// delays assume al 0, cl 5, cwl 5 as the bench sets them
	a_strobe_preamble: assert property (isRd |-> ##5 (devDqsOe && !devDqOe && !devDqs))
		else $error("read preamble misplaced");
	// modes with the upper bit set chop every burst, whatever the burst bit says
	a_long_burst: assert property (isRd && addr[12] && !burstMode[1] |->
		##6 (devDqOe && devDqs)[*4] ##1 !(devDqOe || devDqsOe))
		else $error("eight beat read wrong length");
	a_chop_burst: assert property (isRd && (!addr[12] || burstMode[1]) |->
		##6 devDqOe[*2] ##1 !(devDqOe || devDqsOe))
		else $error("chopped read wrong length");
	a_write_burst: assert property (isWr && addr[12] |-> ##6 (ctlDqOe && ctlDqsOe)[*4] ##1 !ctlDqOe)
		else $error("write burst misplaced");
	a_col_gap: assert property (isRd || isWr |=> (!(isRd || isWr))[*3])
		else $error("column commands too close");
	a_rd_to_pre: assert property (isRd |=> (cmd != dbrw_pkg::CMD_PRE)[*3])
		else $error("precharge too soon after read");
	a_ras_min: assert property (isAct |=> cmd != dbrw_pkg::CMD_PRE)
		else $error("precharge too soon after activate");
	a_row_cycle: assert property (isAct |=> (!isAct)[*2])
		else $error("activate too soon");
	a_data_strobe: assert property (devDqOe |-> devDqsOe && devDqs)
		else $error("read data without strobe");

	c_long_read: cover property (isRd && addr[12]);
	c_chop_read: cover property (isRd && !addr[12]);
	c_chop_write: cover property (isWr && !addr[12]);
endmodule : dbrw_link_monitor
`default_nettype wire

// File: tb/test_ddr3_burst_read_write_control.sv
// self-checking bench joining controller and device
`timescale 1ns/10ps
`default_nettype none
module test_ddr3_burst_read_write_control;
	logic                core_clk    = 1'b0;
	logic                sys_rst     = 1'b1;
	logic [1:0]          burstMode   = 2'h1;
	logic [4:0]          al          = 5'h0;
	logic [4:0]          cl          = 5'h5;
	logic [4:0]          cwl         = 5'h5;
	logic                dllLocked   = 1'b0;
	logic                usrReqValid = 1'b0;
	dbrw_pkg::dbrw_req_t usrReq      = '0;
	logic                usrReqReady;
	logic                usrRdValid;
	logic [31:0]         usrRdData;
	logic                strobeTrusted;
	logic                timingFault;
	logic                wsFault;
	int                  wsSeen          = 0;
	logic [31:0]         rdQ[$];
	int                  err_count       = 0;
	int                  samples_checked = 0;

	dbrw_link link();
	always #10 core_clk = ~core_clk;
	always @(negedge core_clk) if (usrRdValid === 1'b1) rdQ.push_back(usrRdData);
	always @(negedge core_clk) if (wsFault === 1'b1) wsSeen++;

	dbrw_device u_dbrw_device (.core_clk, .sys_rst, .link(link), .burstMode, .addLatency(al),
		.casLatency(cl), .cwLatency(cwl), .dllLocked, .strobeTrusted, .writeStrobeFault(wsFault),
		.timingFault);
	dbrw_controller u_dbrw_controller (.core_clk, .sys_rst, .link(link), .addLatency(al),
		.casLatency(cl), .cwLatency(cwl), .usrReqValid, .usrReqReady, .usrReq, .usrRdValid,
		.usrRdData);
	dbrw_link_monitor u_dbrw_link_monitor (.core_clk, .sys_rst, .cmd(link.cmd), .addr(link.addr),
		.ctlDqOe(link.ctlDqOe), .ctlDqsOe(link.ctlDqsOe), .devDqOe(link.devDqOe),
		.devDqsOe(link.devDqsOe), .devDqs(link.devDqs), .burstMode);

	//////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check

	task send(input logic wr, input logic ch, input logic [31:0] sd);
		@(negedge core_clk);
		usrReq = '{wr, ch, 3'h2, 13'h0, 10'h8, sd};
		usrReqValid = 1'b1;
		while (usrReqReady !== 1'b1) @(negedge core_clk);
		@(negedge core_clk);
		usrReqValid = 1'b0;
	endtask : send

	// words of one slot come back as seed plus beat index
	task expect_words(input int n, input logic [31:0] sd);
		int k;
		k = 0;
		while (rdQ.size() < n && k < 2000) begin
			@(negedge core_clk);
			k++;
		end
		repeat (20) @(negedge core_clk);
		check(32'(rdQ.size()), 32'(n));
		for (int i = 0; i < n; i++) check(rdQ[i], sd + 32'(i % 4));
		rdQ.delete();
	endtask : expect_words

	task t_rw(input logic [1:0] m, input logic ch, input logic [31:0] sd);
		burstMode = m;
		send(1'b1, ch, sd);
		send(1'b0, ch, sd);
		expect_words((ch | m[1]) ? 2 : 4, sd);
		$display("write read mode %0d chop %0d done", m, ch);
	endtask : t_rw

	task t_dll;
		dllLocked = 1'b1;
		repeat (2) @(negedge core_clk);
		check(32'(strobeTrusted), 32'h1);
		dllLocked = 1'b0;
		repeat (2) @(negedge core_clk);
		check(32'(strobeTrusted), 32'h0);
		$display("loop lock test done");
	endtask : t_dll

	// queue is held full so later requests are refused, then drained
	task t_fill;
		int acc;
		int full;
		acc = 0;
		full = 0;
		@(negedge core_clk);
		usrReq = '{1'b0, 1'b0, 3'h2, 13'h0, 10'h8, 32'h0};
		usrReqValid = 1'b1;
		repeat (60) begin
			if (usrReqReady === 1'b1) acc++;
			else full = 1;
			@(negedge core_clk);
		end
		usrReqValid = 1'b0;
		check(32'(full), 32'h1);
		expect_words(acc * 4, 32'h3000);
		$display("queue fill test done");
	endtask : t_fill

	// mid-run reset: flags clear and traffic resumes
	task t_reinit;
		dllLocked = 1'b1;
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		sys_rst = 1'b0;
		check(32'(strobeTrusted), 32'h0);
		t_rw(2'h1, 1'b0, 32'h5000);
		check(32'(timingFault), 32'h0);
		$display("reset rerun test done");
	endtask : t_reinit

	task wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge core_clk);
		sys_rst = 1'b0;
		t_dll;
		t_rw(2'h1, 1'b0, 32'h1000);
		t_rw(2'h1, 1'b1, 32'h2000);
		t_rw(2'h2, 1'b0, 32'h4000);
		t_rw(2'h0, 1'b0, 32'h3000);
		t_fill;
		check(32'(timingFault), 32'h0);
		check(32'(wsSeen), 32'h0);
		t_reinit;
		wrap_up;
	end

	initial begin
		#400000;
		err_count++;
		wrap_up;
	end
endmodule : test_ddr3_burst_read_write_control
`default_nettype wire
